// ---- acrs_cfg.svh ----
`ifndef ACRS_CFG_SVH
`define ACRS_CFG_SVH

// register offsets
`define ACRS_OFF_RESULT_HI     8'h07
`define ACRS_OFF_RESULT_LO     8'h08
`define ACRS_OFF_CONV_CONFIG   8'h09
`define ACRS_OFF_CHANNEL_CFG   8'h0a
`define ACRS_OFF_REG_SRC_CTRL  8'h0b
`define ACRS_OFF_RSVD_A        8'h0c
`define ACRS_OFF_RSVD_B        8'h0d

// field positions
`define ACRS_READY_BIT         7
`define ACRS_RB_SEL_MSB        5
`define ACRS_RB_SEL_LSB        3
`define ACRS_CONV_SEL_MSB      2
`define ACRS_CONV_SEL_LSB      0
`define ACRS_OVERRIDE_BIT      1
`define ACRS_SRC_BIT           0
`define ACRS_ENABLE_BIT        7
`define ACRS_ONE_SHOT_BIT      6
`define ACRS_SCAN_BIT          5

// reset values
`define ACRS_RST_CHANNEL_CFG   8'h00
`define ACRS_RST_REG_SRC_CTRL  8'h80
`define ACRS_RST_RSVD_A        8'h10
`define ACRS_RST_RSVD_B        8'h08
`define ACRS_RST_CONV_CONFIG   8'h00

// result layout, channel count and code values
`define ACRS_RESULT_W          14
`define ACRS_CHANNELS          8
`define ACRS_INVALID_RB_CODE   3'h4
`define ACRS_SRC_OUTPUT        1'b0
`define ACRS_SRC_INPUT         1'b1

`endif

// ---- acrs_pkg.sv ----
`include "acrs_cfg.svh"

package acrs_pkg;
    typedef logic [`ACRS_RESULT_W-1:0] acrs_result_t;
    typedef logic [2:0]                 acrs_chan_t;

    typedef enum logic [2:0] {
        ACRS_IDLE = 3'b001,
        ACRS_WAIT = 3'b010,
        ACRS_DONE = 3'b100
    } acrs_conv_state_t;
endpackage : acrs_pkg

// ---- acrs_result_if.sv ----
`timescale 1ns/10ps

interface acrs_result_if;
    import acrs_pkg::*;
    logic         wr_en;
    acrs_chan_t   wr_chan;
    acrs_result_t wr_data;
    acrs_chan_t   rd_chan;
    acrs_result_t rd_data;

    modport owner (output wr_en, output wr_chan, output wr_data, output rd_chan,
                   input rd_data);
    modport store (input wr_en, input wr_chan, input wr_data, input rd_chan,
                   output rd_data);
endinterface : acrs_result_if

// ---- acrs_result_mem.sv ----
`timescale 1ns/10ps
`include "acrs_cfg.svh"

module acrs_result_mem
    import acrs_pkg::*;
(
    // clock and reset
    input  wire logic    clock_i,
    input  wire logic    rst_b_i,
    // access
    acrs_result_if.store mem
);
    acrs_result_t store_reg [`ACRS_CHANNELS];
    acrs_result_t rd_reg;

    genvar g;
    generate
        for (g = 0; g < `ACRS_CHANNELS; g++) begin : g_entry
            always_ff @(posedge clock_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    store_reg[g] <= '0;
                end else if (mem.wr_en && mem.wr_chan == 3'(g)) begin
                    store_reg[g] <= mem.wr_data;
                end
            end
        end
    endgenerate

    // registered read, independent of write port
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_reg <= '0;
        end else begin
            rd_reg <= store_reg[mem.rd_chan];
        end
    end

    assign mem.rd_data = rd_reg;
endmodule : acrs_result_mem

// ---- acrs_adc_ctrl.sv ----
// Function
// - bit 7 reads conversion-complete flag
// - bits 5:3 choose readback channel
// - bits 2:0 choose converted channel unless scan is on
// - readback independent of ongoing conversion
// - override low, automatic source choice
// - override high, manual source forced
// - source bit: 0 output, 1 input
// - result split, high eight and low six
// - one-shot single pass, else continuous
`timescale 1ns/10ps
`include "acrs_cfg.svh"

module acrs_adc_ctrl
    import acrs_pkg::*;
(
    // clock and reset
    input  wire logic               clock_i,
    input  wire logic               rst_b_i,
    // register port
    input  wire logic               reg_wr_i,
    input  wire logic               reg_rd_i,
    input  wire logic [7:0]         reg_addr_i,
    input  wire logic [7:0]         reg_wdata_i,
    output logic      [7:0]         reg_rdata_o,
    // converter core
    output logic                    conv_start_o,
    output logic      [2:0]         conv_chan_o,
    input  wire logic               conv_done_i,
    input  wire logic [13:0]        conv_data_i,
    // regulator supply switch
    input  wire logic               auto_src_i,
    output logic                    reg_src_o
);
    logic         rst_meta_reg;
    logic         rst_sync_reg;
    logic         done_meta_reg;
    logic         done_sync_reg;
    logic         done_seen_reg;
    logic         auto_meta_reg;
    logic         auto_sync_reg;
    logic         done_pulse;

    logic [7:0]   conv_cfg_reg;
    logic [2:0]   rb_sel_reg;
    logic [2:0]   conv_sel_reg;
    logic         ready_reg;
    logic [1:0]   src_ctrl_reg;
    logic [7:0]   rsvd_a_reg;
    logic [7:0]   rsvd_b_reg;
    logic [5:0]   rsvd_src_reg;
    logic [2:0]   scan_chan_reg;
    logic [7:0]   rdata_next;
    logic         wr_conv_cfg;
    logic         result_read;
    logic         src_next;
    logic         conv_en;
    logic         one_shot;
    logic         scan_all;
    acrs_conv_state_t state_reg;
    acrs_result_t rb_data;
    acrs_result_t data_meta_reg;
    acrs_result_t data_sync_reg;
    acrs_chan_t   wr_slot;
    logic         slot_ok;
    logic         conv_finish;

    localparam logic [7:0] RST_CHAN = `ACRS_RST_CHANNEL_CFG;
    localparam logic [7:0] RST_SRC  = `ACRS_RST_REG_SRC_CTRL;

    acrs_result_if res_if ();

    acrs_result_mem u_mem (
        .clock_i (clock_i),
        .rst_b_i (rst_sync_reg),
        .mem     (res_if.store)
    );

    // reset release
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // analog-side inputs arrive asynchronously
    always_ff @(posedge clock_i or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            done_meta_reg <= 1'b0;
            done_sync_reg <= 1'b0;
            done_seen_reg <= 1'b0;
            auto_meta_reg <= 1'b0;
            auto_sync_reg <= 1'b0;
            data_meta_reg <= '0;
            data_sync_reg <= '0;
        end else begin
            done_meta_reg <= conv_done_i;
            done_sync_reg <= done_meta_reg;
            done_seen_reg <= done_sync_reg;
            auto_meta_reg <= auto_src_i;
            auto_sync_reg <= auto_meta_reg;
            data_meta_reg <= conv_data_i;
            data_sync_reg <= data_meta_reg;
        end
    end

    assign done_pulse  = done_sync_reg && !done_seen_reg;
    assign wr_conv_cfg = reg_wr_i && reg_addr_i == `ACRS_OFF_CONV_CONFIG;
    assign conv_en     = conv_cfg_reg[`ACRS_ENABLE_BIT];
    assign one_shot    = conv_cfg_reg[`ACRS_ONE_SHOT_BIT];
    assign scan_all    = conv_cfg_reg[`ACRS_SCAN_BIT];
    assign result_read = reg_rd_i && (reg_addr_i == `ACRS_OFF_RESULT_HI
                                   || reg_addr_i == `ACRS_OFF_RESULT_LO);

    // register writes
    always_ff @(posedge clock_i or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            conv_cfg_reg <= `ACRS_RST_CONV_CONFIG;
            rb_sel_reg   <= RST_CHAN[`ACRS_RB_SEL_MSB:`ACRS_RB_SEL_LSB];
            conv_sel_reg <= RST_CHAN[`ACRS_CONV_SEL_MSB:`ACRS_CONV_SEL_LSB];
            src_ctrl_reg <= RST_SRC[1:0];
            rsvd_src_reg <= RST_SRC[7:2];
            rsvd_a_reg   <= `ACRS_RST_RSVD_A;
            rsvd_b_reg   <= `ACRS_RST_RSVD_B;
        end else if (reg_wr_i) begin
            unique case (reg_addr_i)
                `ACRS_OFF_CONV_CONFIG: begin
                    conv_cfg_reg <= {reg_wdata_i[7:3], conv_cfg_reg[2:0]};
                end
                `ACRS_OFF_CHANNEL_CFG: begin
                    rb_sel_reg   <= reg_wdata_i[`ACRS_RB_SEL_MSB:`ACRS_RB_SEL_LSB];
                    conv_sel_reg <= reg_wdata_i[`ACRS_CONV_SEL_MSB:`ACRS_CONV_SEL_LSB];
                end
                `ACRS_OFF_REG_SRC_CTRL: begin
                    src_ctrl_reg <= reg_wdata_i[1:0];
                    rsvd_src_reg <= reg_wdata_i[7:2];
                end
                `ACRS_OFF_RSVD_A: begin
                    rsvd_a_reg <= reg_wdata_i;
                end
                `ACRS_OFF_RSVD_B: begin
                    rsvd_b_reg <= reg_wdata_i;
                end
                default: begin
                end
            endcase
        end
    end

    // conversion sequencing
    always_ff @(posedge clock_i or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            state_reg     <= ACRS_IDLE;
            scan_chan_reg <= 3'h0;
        end else if (!conv_en) begin
            state_reg     <= ACRS_IDLE;
            scan_chan_reg <= 3'h0;
        end else begin
            unique case (state_reg)
                ACRS_IDLE: begin
                    state_reg <= ACRS_WAIT;
                end
                ACRS_WAIT: begin
                    if (done_pulse) begin
                        if (scan_all && scan_chan_reg != 3'h7) begin
                            scan_chan_reg <= scan_chan_reg + 3'h1;
                            state_reg     <= ACRS_IDLE;
                        end else if (one_shot) begin
                            state_reg     <= ACRS_DONE;
                        end else begin
                            scan_chan_reg <= 3'h0;
                            state_reg     <= ACRS_IDLE;
                        end
                    end
                end
                ACRS_DONE: begin
                    if (wr_conv_cfg) begin
                        scan_chan_reg <= 3'h0;
                        state_reg     <= ACRS_IDLE;
                    end
                end
            endcase
        end
    end

    assign conv_start_o = state_reg == ACRS_IDLE && conv_en;
    assign conv_chan_o  = scan_all ? scan_chan_reg : conv_sel_reg;

    // conversion write port and readback port run separately
    assign conv_finish    = state_reg == ACRS_WAIT && done_pulse;

    // results are kept under the readback code of the same channel
    always_comb begin
        wr_slot = conv_chan_o;
        slot_ok = 1'b1;
        unique case (conv_chan_o)
            3'h0:    wr_slot = 3'h3;
            3'h1:    wr_slot = 3'h2;
            3'h2:    slot_ok = 1'b0;   // battery has no readback code
            3'h3:    wr_slot = 3'h0;
            default: wr_slot = conv_chan_o;
        endcase
    end

    assign res_if.wr_en   = conv_finish && slot_ok;
    assign res_if.wr_chan = wr_slot;
    assign res_if.wr_data = data_sync_reg;
    assign res_if.rd_chan = rb_sel_reg;
    assign rb_data        = res_if.rd_data;

    // ready flag: completion beats a clearing read
    always_ff @(posedge clock_i or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            ready_reg <= 1'b0;
        end else if (conv_finish) begin
            ready_reg <= 1'b1;
        end else if (result_read) begin
            ready_reg <= 1'b0;
        end
    end

    // regulator source select
    always_comb begin
        if (src_ctrl_reg[`ACRS_OVERRIDE_BIT]) begin
            src_next = src_ctrl_reg[`ACRS_SRC_BIT];
        end else begin
            src_next = auto_sync_reg;
        end
    end

    always_ff @(posedge clock_i or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            reg_src_o <= `ACRS_SRC_OUTPUT;
        end else begin
            reg_src_o <= src_next;
        end
    end

    // read mux
    always_comb begin
        unique case (reg_addr_i)
            `ACRS_OFF_RESULT_HI:    rdata_next = rb_data[13:6];
            `ACRS_OFF_RESULT_LO:    rdata_next = {2'h0, rb_data[5:0]};
            `ACRS_OFF_CONV_CONFIG:  rdata_next = conv_cfg_reg;
            `ACRS_OFF_CHANNEL_CFG:  rdata_next = {ready_reg, 1'b0, rb_sel_reg,
                                                  conv_sel_reg};
            `ACRS_OFF_REG_SRC_CTRL: rdata_next = {rsvd_src_reg, src_ctrl_reg};
            `ACRS_OFF_RSVD_A:       rdata_next = rsvd_a_reg;
            `ACRS_OFF_RSVD_B:       rdata_next = rsvd_b_reg;
            default:                rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rdata_next;
        end
    end
endmodule : acrs_adc_ctrl

// ---- acrs_adc_ctrl_props.sv ----
`timescale 1ns/10ps
module acrs_adc_ctrl_props (
    // clock and reset
    input wire logic        clock_i,
    input wire logic        rst_b_i,
    // register port
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic [7:0]  reg_rdata_o,
    // converter and regulator
    input wire logic        conv_start_o,
    input wire logic [2:0]  conv_chan_o,
    input wire logic        conv_done_i,
    input wire logic [13:0] conv_data_i,
    input wire logic        auto_src_i,
    input wire logic        reg_src_o
);
    logic [5:0] chan_q;
    logic [2:0] conv_q;
    logic [1:0] src_q;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    // shadow of the written control fields
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            chan_q <= '0;
            conv_q <= '0;
            src_q  <= '0;
        end else if (reg_wr_i) begin
            if (reg_addr_i == 8'h0a) chan_q <= reg_wdata_i[5:0];
            if (reg_addr_i == 8'h09) conv_q <= reg_wdata_i[7:5];
            if (reg_addr_i == 8'h0b) src_q <= reg_wdata_i[1:0];
        end
    end
    AST_CONV_CHAN: assert property (!conv_q[0] |-> conv_chan_o == chan_q[2:0])
        else $error("converted channel differs from setting");
    AST_CFG_READ: assert property (reg_rd_i && reg_addr_i == 8'h0a |=>
        reg_rdata_o[6:0] == {1'b0, chan_q}) else $error("channel fields read wrong");
    AST_LO_PAD: assert property (reg_rd_i && reg_addr_i == 8'h08 |=>
        reg_rdata_o[7:6] == 2'b00) else $error("low result padding not zero");
    AST_UNMAPPED: assert property (reg_rd_i && reg_addr_i > 8'h0d |=>
        reg_rdata_o == 8'h00) else $error("unmapped read not zero");
    AST_START_PULSE: assert property (conv_start_o |=> !conv_start_o)
        else $error("start longer than one cycle");
    AST_RESTART: assert property ($rose(conv_done_i) && conv_q == 3'b100 |->
        ##[1:6] (conv_start_o || conv_q != 3'b100))
        else $error("continuous mode did not restart");
    AST_ONESHOT_STOP: assert property ($rose(conv_done_i) && conv_q == 3'b110 |=>
        !conv_start_o [*6]) else $error("one-shot mode restarted");
    AST_SRC_MANUAL: assert property ((src_q[1] && $stable(src_q))[*4] |->
        reg_src_o == src_q[0]) else $error("manual source not forced");
    AST_SRC_AUTO: assert property ((!src_q[1] && $stable(auto_src_i))[*7] |->
        reg_src_o == auto_src_i) else $error("automatic source not followed");
    CV_START: cover property (conv_start_o);
    CV_SCAN: cover property (conv_q == 3'b111 && conv_start_o);
    CV_MANUAL: cover property (src_q[1] && reg_src_o);
    CV_RESULT_READ: cover property (reg_rd_i && reg_addr_i == 8'h07);
endmodule : acrs_adc_ctrl_props

bind acrs_adc_ctrl acrs_adc_ctrl_props u_props (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .conv_start_o(conv_start_o), .conv_chan_o(conv_chan_o), .conv_done_i(conv_done_i),
    .conv_data_i(conv_data_i), .auto_src_i(auto_src_i), .reg_src_o(reg_src_o));

// ---- acrs_conv_model.sv ----
`timescale 1ns/10ps
module acrs_conv_model (
    // clock
    input  wire logic        clock_i,
    // converter link
    input  wire logic        start_i,
    input  wire logic [7:0]  dly_i,
    input  wire logic [13:0] data_i,
    output logic             done_o,
    output logic      [13:0] data_o
);
    int n_req = 0;
    int n_done = 0;
    always @(posedge clock_i) begin
        if (start_i) n_req <= n_req + 1;
    end
    // done held several cycles, data garbled once released
    initial begin
        done_o = 1'b0;
        data_o = '0;
        forever begin
            @(posedge clock_i);
            if (n_req > n_done) begin
                n_done++;
                repeat (dly_i) @(posedge clock_i);
                data_o <= data_i;
                done_o <= 1'b1;
                repeat (4) @(posedge clock_i);
                done_o <= 1'b0;
                data_o <= ~data_i;
            end
        end
    end
endmodule : acrs_conv_model

// ---- tb.sv ----
`timescale 1ns/10ps
module tb;
    import acrs_pkg::*;
    logic         clock_i, rst_b_i, reg_wr_i, reg_rd_i, auto_src_i;
    logic         conv_start_o, conv_done_i, reg_src_o;
    logic [7:0]   reg_addr_i, reg_wdata_i, reg_rdata_o, d, dly, v;
    logic [2:0]   conv_chan_o, rb;
    acrs_result_t conv_data_i, nxt;
    acrs_result_t exp_q [8];
    int           n_errors, checks, last;
    int           rbm [8] = '{3, 2, 1, 0, 4, 5, 6, 7};
    logic [7:0]   ra [7] = '{8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h07, 8'h08, 8'h20};
    logic [7:0]   rv [7] = '{8'h00, 8'h80, 8'h10, 8'h08, 8'h00, 8'h00, 8'h00};
    acrs_adc_ctrl u_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .conv_start_o(conv_start_o), .conv_chan_o(conv_chan_o),
        .conv_done_i(conv_done_i), .conv_data_i(conv_data_i), .auto_src_i(auto_src_i),
        .reg_src_o(reg_src_o));
    acrs_conv_model u_conv (.clock_i(clock_i), .start_i(conv_start_o), .dly_i(dly),
        .data_i(nxt), .done_o(conv_done_i), .data_o(conv_data_i));
    task automatic chk(input logic [7:0] seen, input logic [7:0] expv);
        checks++;
        if (seen !== expv) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] x);
        @(posedge clock_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= x;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clock_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        @(posedge clock_i);
        d = reg_rdata_o;
    endtask : rd
    task automatic wait_ready;
        for (int k = 0; k < 100; k++) begin
            rd(8'h0a);
            if (d[7] === 1'b1) break;
        end
        chk(d & 8'h80, 8'h80);
    endtask : wait_ready
    task automatic summarize;
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize
    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    initial begin
        repeat (60000) @(posedge clock_i);
        n_errors++;
        summarize();
    end
    initial begin
        {rst_b_i, reg_wr_i, reg_rd_i, auto_src_i, reg_addr_i, reg_wdata_i} = '0;
        {n_errors, checks, dly, nxt} = '0;
        last = -1;
        rb = 3'h1;
        void'($urandom(84583));
        repeat (5) @(posedge clock_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        foreach (ra[k]) begin
            rd(ra[k]);
            chk(d, rv[k]);
        end
        // one-shot per channel, reading an older result while busy
        for (int i = 0; i < 8; i++) begin
            nxt <= acrs_result_t'($urandom);
            dly <= 8'($urandom_range(12, 30));
            wr(8'h0a, {2'b00, rb, 3'(i)});
            wr(8'h09, 8'hc0);
            if (last >= 0) begin
                rd(8'h07);
                chk(d, 8'(exp_q[last] >> 6));
            end
            wait_ready();
            exp_q[i] = nxt;
            if (i != 2) begin
                rb = 3'(rbm[i]);
                last = i;
                wr(8'h0a, {2'b00, rb, 3'(i)});
                repeat (2) @(posedge clock_i);
                rd(8'h07);
                chk(d, 8'(exp_q[i] >> 6));
                rd(8'h08);
                chk(d, {2'b00, exp_q[i][5:0]});
                rd(8'h0a);
                chk(d, {2'b00, rb, 3'(i)});
            end
        end
        nxt <= acrs_result_t'($urandom);
        dly <= 8'h05;
        wr(8'h09, 8'h80);
        repeat (2) begin
            wait_ready();
            rd(8'h07);
            chk(d, 8'(nxt >> 6));
        end
        wr(8'h09, 8'h00);
        for (int j = 0; j < 8; j++) begin
            v = 8'h80 | 8'(j % 4);
            auto_src_i <= 1'($urandom);
            wr(8'h0b, v);
            repeat (8) @(posedge clock_i);
            chk({7'h0, reg_src_o}, {7'h0, v[1] ? v[0] : auto_src_i});
            rd(8'h0b);
            chk(d, v);
        end
        // scan all once; channel 2 (battery) is converted but has no readback code, so slot 1 stays 0
        nxt <= acrs_result_t'($urandom);
        wr(8'h09, 8'he0);
        repeat (120) @(posedge clock_i);
        for (int c = 0; c < 8; c++) begin
            wr(8'h0a, {2'b00, 3'(c), 3'h0});
            repeat (2) @(posedge clock_i);
            rd(8'h07);
            chk(d, (c == 1) ? 8'h00 : 8'(nxt >> 6));
        end
        summarize();
    end
endmodule : tb
